// File: pkg/sdram_pkg.sv
// Purpose: shared constants, command enumeration and burst helpers for the sdram command interface
// Assumes: one clock, pins sampled on its rising edge, two banks of 512 rows by 256 columns
// Notes  : mode register field layout is defined here and nowhere else
// Functional notes
// RULE1: inputs sampled only on rising clock edge
// RULE2: select low validates command, high ignores inputs
// RULE3: row open captures row from A0-A8
// RULE4: read/store captures column A0-A7 as start
// RULE5: precharge A8 high closes both banks
// RULE6: A9 picks bank; 512 rows, 256 columns
// RULE7: clock gate low invalidates the next edge
// RULE8: read byte mask high floats that byte
// RULE9: write byte mask high keeps stored byte
// RULE10: deselect and no-op execute nothing, keep state
// RULE11: column strobe commands: read/store, A8 autoclose
// RULE12: row strobe commands: row open or precharge
// RULE13: burst halt stops full page; page wraps
// RULE14: read bursts from latched address, then floats
// RULE15: read autoclose precharges after short burst
// RULE16: store bursts, or single write in single mode
// RULE17: store autoclose precharges after short burst
// RULE18: row open activates picked bank and row
// RULE19: bank close one bank, all close every bank
// RULE20: refresh command; clock gate picks auto/self
// RULE21: mode load from address pins, A9 A8 low
// RULE22: byte masks act only after clock gate high
// RULE23: auto-refresh advances counter, 1024 cover array
// RULE24: self-refresh runs while clock gate low
// RULE25: mode register holds length, order, latency, write mode
package sdram_pkg;

    // pin and array geometry
    localparam int ADDR_W      = 10;
    localparam int DATA_W      = 16;
    localparam int ROW_W       = 9;
    localparam int COL_W       = 8;
    localparam int BYTE_W      = 8;
    localparam int MEM_IDX_W   = 1 + ROW_W + COL_W;
    localparam int BANK_BIT    = 9;
    localparam int ALL_BIT     = 8;
    localparam int REF_CNT_W   = 10;

    // mode register fields
    localparam int BL_LSB      = 0;
    localparam int BL_MSB      = 2;
    localparam int ORDER_BIT   = 3;
    localparam int LAT_LSB     = 4;
    localparam int LAT_MSB     = 6;
    localparam int WMODE_BIT   = 9;
    localparam logic [ADDR_W-1:0] MODE_RESET = 10'h020;

    // burst length codes
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;

    // read latency codes
    localparam logic [2:0] LAT_ONE = 3'h1;
    localparam logic [2:0] LAT_TWO = 3'h2;

    // auto-refresh busy time in cycles
    localparam logic [2:0] REFRESH_CYCLES = 3'h4;

    // decoded commands
    typedef enum logic [3:0] {
        CMD_DESELECT, CMD_NOP, CMD_BURST_HALT, CMD_READ, CMD_STORE,
        CMD_ROW_OPEN, CMD_BANK_CLOSE, CMD_REFRESH, CMD_MODE_LOAD, CMD_INHIBIT
    } cmd_e;

    // burst engine and power states
    typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE} op_e;
    typedef enum logic [1:0] {ST_RUN, ST_AUTOREF, ST_SELFREF} state_e;

    // wrap mask of a burst length code
    function automatic logic [COL_W-1:0] len_mask(input logic [2:0] code);
        case (code)
            BL_1:    len_mask = 8'h00;
            BL_2:    len_mask = 8'h01;
            BL_4:    len_mask = 8'h03;
            BL_8:    len_mask = 8'h07;
            default: len_mask = 8'hFF;
        endcase
    endfunction : len_mask

    // column of the n-th word of a burst, sequential or interleaved
    function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start, input logic [COL_W-1:0] cnt,
                                                   input logic [COL_W-1:0] mask, input logic ilv);
        logic [COL_W-1:0] sum;
        sum = start + cnt;
        if (ilv)
            burst_col = (start & ~mask) | ((start ^ cnt) & mask);
        else
            burst_col = (start & ~mask) | (sum & mask);
    endfunction : burst_col

endpackage : sdram_pkg

// File: pkg/sdram_cmd_if.sv
// Purpose: carries one decoded command from the pin decoder to the core
// Assumes: all fields are combinational from the pins of the current cycle
// Notes  : the core samples these on its clock edge
`timescale 1ns/100ps
interface sdram_cmd_if;
    sdram_pkg::cmd_e              cmd;       // decoded command
    logic                         bank;      // bank pick
    logic                         a8;        // autoclose or all-banks flag
    logic [sdram_pkg::ROW_W-1:0]  row;       // row address
    logic [sdram_pkg::COL_W-1:0]  col;       // column address
    logic [sdram_pkg::ADDR_W-1:0] modeBits;  // mode load value

    modport decoder (output cmd, bank, a8, row, col, modeBits);
    modport core    (input  cmd, bank, a8, row, col, modeBits);
endinterface : sdram_cmd_if

// File: core/sdram_cmd_decode.sv
// Purpose: decodes select, strobes and address pins into a command
// Assumes: pins are stable around the rising clock edge
// Notes  : purely combinational; the core does all sampling
`timescale 1ns/100ps
module sdram_cmd_decode (
    // command pins
    input  wire logic                         cmdSelectN,
    input  wire logic                         rowStrobeN,
    input  wire logic                         colStrobeN,
    input  wire logic                         writeStrobeN,
    input  wire logic [sdram_pkg::ADDR_W-1:0] addr,
    // decoded command
    sdram_cmd_if.decoder                      cmdPort
);
    // strobe pattern, row-col-write
    wire logic [2:0] strobes = {rowStrobeN, colStrobeN, writeStrobeN};
    wire logic       modeOk  = ~addr[sdram_pkg::BANK_BIT] & ~addr[sdram_pkg::ALL_BIT];

    // command selection
    assign cmdPort.cmd =
        cmdSelectN         ? sdram_pkg::CMD_DESELECT :   // RULE2 RULE10
        (strobes == 3'h7)  ? sdram_pkg::CMD_NOP :        // RULE10
        (strobes == 3'h6)  ? sdram_pkg::CMD_BURST_HALT :
        (strobes == 3'h5)  ? sdram_pkg::CMD_READ :       // RULE11
        (strobes == 3'h4)  ? sdram_pkg::CMD_STORE :      // RULE11
        (strobes == 3'h3)  ? sdram_pkg::CMD_ROW_OPEN :   // RULE12
        (strobes == 3'h2)  ? sdram_pkg::CMD_BANK_CLOSE : // RULE12
        (strobes == 3'h1)  ? sdram_pkg::CMD_REFRESH :    // RULE20
        modeOk             ? sdram_pkg::CMD_MODE_LOAD :  // RULE21
                             sdram_pkg::CMD_INHIBIT;

    // address fields
    assign cmdPort.bank     = addr[sdram_pkg::BANK_BIT];            // RULE6
    assign cmdPort.a8       = addr[sdram_pkg::ALL_BIT];             // RULE11 RULE12
    assign cmdPort.row      = addr[sdram_pkg::ROW_W-1:0];           // RULE3
    assign cmdPort.col      = addr[sdram_pkg::COL_W-1:0];           // RULE4
    assign cmdPort.modeBits = addr;                                 // RULE21
endmodule : sdram_cmd_decode

// File: core/sdram_command_interface.sv
// Purpose: command, bank, burst, refresh and byte-mask logic of a two-bank 16-bit sdram
// Assumes: the controller keeps timing and only issues legal sequences
// Notes  : the data pin is split into readData, dataOutEnN and storeData
`timescale 1ns/100ps
module sdram_command_interface (
    // clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rstn,
    // command pins
    input  wire logic                         cmdSelectN,
    input  wire logic                         rowStrobeN,
    input  wire logic                         colStrobeN,
    input  wire logic                         writeStrobeN,
    input  wire logic                         clockGate,
    input  wire logic [sdram_pkg::ADDR_W-1:0] addr,
    // byte masks
    input  wire logic                         upperByteMask,
    input  wire logic                         lowerByteMask,
    // data pin, split
    input  wire logic [sdram_pkg::DATA_W-1:0] storeData,
    output logic      [sdram_pkg::DATA_W-1:0] readData,
    output logic      [1:0]                   dataOutEnN,
    // status
    output logic      [1:0]                   bankOpen,
    output logic      [sdram_pkg::ADDR_W-1:0] modeReg,
    output logic      [sdram_pkg::REF_CNT_W-1:0] refreshRow,
    output logic                              burstActive,
    output logic                              autoRefreshBusy,
    output logic                              selfRefresh,
    output logic                              illegalCmd
);
    localparam int HI = sdram_pkg::DATA_W - 1;
    localparam int LO = sdram_pkg::BYTE_W - 1;

    // decoded command from the pins
    sdram_cmd_if cmdBus ();

    sdram_cmd_decode u_decode (
        .cmdSelectN   (cmdSelectN),
        .rowStrobeN   (rowStrobeN),
        .colStrobeN   (colStrobeN),
        .writeStrobeN (writeStrobeN),
        .addr         (addr),
        .cmdPort      (cmdBus.decoder)
    );

    // state registers
    logic                              cgPrev_q;          // clock gate from previous edge
    sdram_pkg::state_e                 state_q, state_d;  // power state
    sdram_pkg::op_e                    op_q;              // running burst kind
    logic                              burstBank_q;       // bank of the burst
    logic [sdram_pkg::COL_W-1:0]       burstStart_q;      // start column
    logic [sdram_pkg::COL_W-1:0]       burstCnt_q;        // next word index
    logic                              autoClose_q;       // precharge at burst end
    logic [2:0]                        refWait_q;         // auto-refresh busy count
    logic [sdram_pkg::ROW_W-1:0]       rowAddr_q [2];     // open row per bank
    logic [1:0]                        bankOpen_q;        // open banks
    logic [sdram_pkg::ADDR_W-1:0]      modeReg_q;         // mode register
    logic [sdram_pkg::REF_CNT_W-1:0]   refreshRow_q;      // refresh address counter
    logic [sdram_pkg::DATA_W-1:0]      pipeData_q [2];    // read latency stages
    logic [1:0]                        pipeValid_q;       // stage valid
    logic [sdram_pkg::DATA_W-1:0]      readData_q;        // data pin output
    logic [1:0]                        dataOutEnN_q;      // byte drive enables, low drives
    logic                              selfRef_q;         // self-refresh flag
    logic                              autoRef_q;         // auto-refresh flag
    logic                              illegal_q;         // illegal command pulse

    // array of both banks
    logic [sdram_pkg::DATA_W-1:0]      mem [0:(2**sdram_pkg::MEM_IDX_W)-1];

    // edge qualification
    wire logic edgeValid = cgPrev_q;                                          // RULE7 RULE22
    wire logic cmdTake   = edgeValid && (state_q == sdram_pkg::ST_RUN);       // RULE1 RULE2
    wire logic isRead    = cmdTake && (cmdBus.cmd == sdram_pkg::CMD_READ);
    wire logic isStore   = cmdTake && (cmdBus.cmd == sdram_pkg::CMD_STORE);
    wire logic isOpen    = cmdTake && (cmdBus.cmd == sdram_pkg::CMD_ROW_OPEN);
    wire logic isClose   = cmdTake && (cmdBus.cmd == sdram_pkg::CMD_BANK_CLOSE);
    wire logic isHalt    = cmdTake && (cmdBus.cmd == sdram_pkg::CMD_BURST_HALT);
    wire logic isRefresh = cmdTake && (cmdBus.cmd == sdram_pkg::CMD_REFRESH);
    wire logic isMode    = cmdTake && (cmdBus.cmd == sdram_pkg::CMD_MODE_LOAD);

    // mode register fields
    wire logic [2:0] blCode     = modeReg_q[sdram_pkg::BL_MSB:sdram_pkg::BL_LSB];    // RULE25
    wire logic [2:0] latCode    = modeReg_q[sdram_pkg::LAT_MSB:sdram_pkg::LAT_LSB];  // RULE25
    wire logic       interleave = modeReg_q[sdram_pkg::ORDER_BIT];                   // RULE25
    wire logic       singleWr   = modeReg_q[sdram_pkg::WMODE_BIT];                   // RULE25
    wire logic       fullPage   = (blCode == sdram_pkg::BL_FULL);

    // burst access selection; an issue edge moves its first word at once
    wire logic       issue      = (isRead || isStore) && bankOpen_q[cmdBus.bank];    // RULE14 RULE16
    wire logic       running    = edgeValid && (op_q != sdram_pkg::OP_NONE);
    wire logic       accActive  = issue || running;
    wire logic       accWrite   = issue ? isStore : (op_q == sdram_pkg::OP_WRITE);
    wire logic       accBank    = issue ? cmdBus.bank : burstBank_q;
    wire logic [7:0] accStart   = issue ? cmdBus.col : burstStart_q;                 // RULE4
    wire logic [7:0] accCnt     = issue ? 8'h00 : burstCnt_q;
    wire logic       accClose   = issue ? cmdBus.a8 : autoClose_q;
    wire logic       oneWord    = accWrite && singleWr;                              // RULE16
    wire logic       wrapPage   = fullPage && !oneWord;                              // RULE13
    wire logic [7:0] accMask    = oneWord ? 8'h00 : sdram_pkg::len_mask(blCode);
    wire logic [7:0] accCol     = sdram_pkg::burst_col(accStart, accCnt, accMask, interleave);
    wire logic       burstDone  = accActive && !wrapPage && (accCnt == accMask);
    wire logic       burstClose = burstDone && accClose;                             // RULE15 RULE17
    wire logic [sdram_pkg::MEM_IDX_W-1:0] memIdx = {accBank, rowAddr_q[accBank], accCol};

    // a halt, or a precharge of the burst's bank, cuts a running burst
    wire logic       cutBurst   = isHalt || (isClose && (cmdBus.a8 || cmdBus.bank == burstBank_q));

    // read word and latency selection
    wire logic [sdram_pkg::DATA_W-1:0] rdWord = mem[memIdx];
    wire logic       rdValid0   = accActive && !accWrite && !(running && cutBurst && !issue);
    wire logic       outValid   = (latCode == sdram_pkg::LAT_ONE) ? rdValid0 :
                                  (latCode == sdram_pkg::LAT_TWO) ? pipeValid_q[0] : pipeValid_q[1];
    wire logic [sdram_pkg::DATA_W-1:0] outWord =
                                  (latCode == sdram_pkg::LAT_ONE) ? rdWord :
                                  (latCode == sdram_pkg::LAT_TWO) ? pipeData_q[0] : pipeData_q[1];

    // illegal use flags
    wire logic badHalt  = isHalt && running && !fullPage;                            // RULE13
    wire logic badClose = issue && cmdBus.a8 && fullPage && !(isStore && singleWr);  // RULE15 RULE17
    wire logic badCmd   = cmdTake && (cmdBus.cmd == sdram_pkg::CMD_INHIBIT);

    // clock gate history, sampled on every edge
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            cgPrev_q <= 1'b1;
        else
            cgPrev_q <= clockGate;                                                   // RULE7
    end

    // power state machine
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            sdram_pkg::ST_RUN:
            begin
                if (isRefresh && clockGate)
                    state_d = sdram_pkg::ST_AUTOREF;                                 // RULE20
                else if (isRefresh)
                    state_d = sdram_pkg::ST_SELFREF;                                 // RULE20 RULE24
            end
            sdram_pkg::ST_AUTOREF:
            begin
                if (refWait_q == 3'h0)
                    state_d = sdram_pkg::ST_RUN;
            end
            default:
            begin
                if (clockGate)
                    state_d = sdram_pkg::ST_RUN;                                     // RULE24
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_q   <= sdram_pkg::ST_RUN;
            selfRef_q <= 1'b0;
            autoRef_q <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            selfRef_q <= (state_d == sdram_pkg::ST_SELFREF);
            autoRef_q <= (state_d == sdram_pkg::ST_AUTOREF);
        end
    end

    // refresh busy count and refresh address counter
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            refWait_q    <= 3'h0;
            refreshRow_q <= '0;
        end
        else if (isRefresh)
        begin
            refWait_q    <= sdram_pkg::REFRESH_CYCLES - 3'h1;
            refreshRow_q <= refreshRow_q + 10'h001;                                  // RULE23
        end
        else if (state_q == sdram_pkg::ST_SELFREF)
            refreshRow_q <= refreshRow_q + 10'h001;                                  // RULE24
        else if (refWait_q != 3'h0)
            refWait_q    <= refWait_q - 3'h1;
    end

    // mode register
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            modeReg_q <= sdram_pkg::MODE_RESET;
        else if (isMode)
            modeReg_q <= cmdBus.modeBits;                                            // RULE21
    end

    // bank open state and open rows
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            bankOpen_q <= 2'h0;
        else
        begin
            for (int b = 0; b < 2; b++)
            begin
                if (isRefresh)
                    bankOpen_q[b] <= 1'b0;                                           // RULE23
                else if (isOpen && cmdBus.bank == b[0])
                begin
                    bankOpen_q[b] <= 1'b1;                                           // RULE18
                    rowAddr_q[b]  <= cmdBus.row;                                     // RULE3
                end
                else if (isClose && (cmdBus.a8 || cmdBus.bank == b[0]))
                    bankOpen_q[b] <= 1'b0;                                           // RULE5 RULE19
                else if (burstClose && accBank == b[0])
                    bankOpen_q[b] <= 1'b0;                                           // RULE15 RULE17
            end
        end
    end

    // burst engine
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            op_q <= sdram_pkg::OP_NONE;
        else if (issue)
        begin
            op_q         <= burstDone ? sdram_pkg::OP_NONE : (isStore ? sdram_pkg::OP_WRITE : sdram_pkg::OP_READ);
            burstBank_q  <= cmdBus.bank;
            burstStart_q <= cmdBus.col;
            burstCnt_q   <= 8'h01;
            autoClose_q  <= cmdBus.a8;
        end
        else if (running)
        begin
            if (cutBurst || burstDone)
                op_q <= sdram_pkg::OP_NONE;                                          // RULE13
            else
                burstCnt_q <= burstCnt_q + 8'h01;                                    // RULE13
        end
    end

    // byte-masked array write
    always_ff @(posedge sys_clk)
    begin
        if (accActive && accWrite && !(running && cutBurst && !issue))
        begin
            if (!upperByteMask)
                mem[memIdx][HI:sdram_pkg::BYTE_W] <= storeData[HI:sdram_pkg::BYTE_W]; // RULE9
            if (!lowerByteMask)
                mem[memIdx][LO:0] <= storeData[LO:0];                                // RULE9
        end
    end

    // read latency pipeline and data pin drivers; a dead edge holds them
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            pipeValid_q  <= 2'h0;
            readData_q   <= '0;
            dataOutEnN_q <= 2'h3;
        end
        else if (edgeValid)
        begin
            pipeValid_q   <= {pipeValid_q[0], rdValid0};
            pipeData_q[0] <= rdWord;
            pipeData_q[1] <= pipeData_q[0];
            readData_q    <= outWord;                                                // RULE14
            dataOutEnN_q  <= {~(outValid & ~upperByteMask), ~(outValid & ~lowerByteMask)}; // RULE8 RULE22
        end
    end

    // illegal command pulse
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            illegal_q <= 1'b0;
        else
            illegal_q <= badHalt || badClose || badCmd;
    end

    // outputs
    assign readData        = readData_q;
    assign dataOutEnN      = dataOutEnN_q;
    assign bankOpen        = bankOpen_q;
    assign modeReg         = modeReg_q;
    assign refreshRow      = refreshRow_q;
    assign burstActive     = (op_q != sdram_pkg::OP_NONE) ? 1'b1 : 1'b0;
    assign autoRefreshBusy = autoRef_q;
    assign selfRefresh     = selfRef_q;
    assign illegalCmd      = illegal_q;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_close_issue;
        issue && cmdBus.a8 && !fullPage && sdram_pkg::len_mask(blCode) == 8'h00 && !isStore;
    endsequence
    sequence s_bank_closed;
        ##1 !bankOpen_q[$past(cmdBus.bank)];
    endsequence

    chk_deselect_holds: assert property (cmdSelectN |=> $stable(modeReg_q)) // RULE10
        else $error("mode register changed on deselect");
    chk_dead_edge: assert property (!cgPrev_q && state_q == sdram_pkg::ST_RUN |=> $stable(modeReg_q) && $stable(readData_q)) // RULE7
        else $error("state changed on a gated edge");
    chk_row_open: assert property (isOpen |=> bankOpen_q[$past(cmdBus.bank)]) // RULE18
        else $error("row open did not open bank");
    chk_all_close: assert property (isClose && cmdBus.a8 |=> bankOpen_q == 2'h0) // RULE5
        else $error("all banks close left a bank open");
    chk_mode_load: assert property (isMode |=> modeReg_q == $past(addr)) // RULE21
        else $error("mode register not loaded from address");
    chk_read_mask: assert property ($past(cgPrev_q) && !dataOutEnN_q[0] |-> $past(!lowerByteMask)) // RULE8
        else $error("lower byte driven while masked");
    chk_refresh_step: assert property (isRefresh |=> refreshRow_q == $past(refreshRow_q) + 10'h001) // RULE23
        else $error("refresh counter did not advance");
    chk_self_stay: assert property (selfRef_q && !clockGate |=> selfRef_q) // RULE24
        else $error("self-refresh left while clock gate low");
    chk_halt_page: assert property (isHalt && running && fullPage |=> op_q == sdram_pkg::OP_NONE) // RULE13
        else $error("halt did not stop full page burst");
    chk_read_autoclose: assert property (s_close_issue |-> s_bank_closed) // RULE15
        else $error("single read autoclose left bank open");
endmodule : sdram_command_interface

// File: tb/mem_ctrl_model.sv
// Purpose: controller model that drives the sdram command pins
// Assumes: pins change just after a rising edge, by non-blocking assignment
// Notes  : strobeN is select, row, column, write strobe from bit 3 down
`timescale 1ns/100ps
module mem_ctrl_model (
    // pins toward the device
    input  wire logic        sys_clk,
    output logic [3:0]       strobeN,
    output logic             clockGate,
    output logic [9:0]       addr,
    output logic [15:0]      storeData,
    output logic [1:0]       byteMask
);
    // idle pins before the first edge
    initial
    begin
        strobeN   = 4'hF;
        clockGate = 1'b1;
        addr      = 10'h000;
        storeData = 16'h0000;
        byteMask  = 2'h0;
    end
    // one command cycle; the device takes it at the following edge
    task automatic drive(input logic [3:0] s, input logic [9:0] a, input logic [15:0] d,
                         input logic [1:0] m, input logic g);
        @(posedge sys_clk);
        strobeN   <= s;
        addr      <= a;
        storeData <= d;
        byteMask  <= m;
        clockGate <= g;
    endtask : drive
endmodule : mem_ctrl_model

// File: tb/sdram_command_interface_tb.sv
// Purpose: self-checking bench for the sdram command interface
// Assumes: mode load of 10'h021 gives burst length 2, latency 2
// Notes  : idle cycles toggle data so stale values never match
`timescale 1ns/100ps
module sdram_command_interface_tb;
    logic        sys_clk     = 1'b0; // 200 MHz clock
    logic        rstn        = 1'b0; // reset, active low
    logic [3:0]  strobeN;            // select and strobes
    logic        clockGate;          // clock gate
    logic [9:0]  addr;               // address pins
    logic [15:0] storeData;          // write data
    logic [1:0]  byteMask;           // upper, lower mask
    logic [15:0] readData;           // read data
    logic [1:0]  dataOutEnN;         // byte drive enables
    logic [1:0]  bankOpen;           // open banks
    logic [9:0]  modeReg;            // mode register
    logic [9:0]  refreshRow;         // refresh counter
    logic        autoRefreshBusy;    // auto-refresh running
    logic        burstActive, selfRefresh, illegalCmd; // status flags
    int          errCount    = 0;    // mismatches
    int          comparisons = 0;    // compares made
    // half period of 2.5 ns
    always #2.5 sys_clk = ~sys_clk;
    mem_ctrl_model ctl (.sys_clk(sys_clk), .strobeN(strobeN), .clockGate(clockGate), .addr(addr),
                        .storeData(storeData), .byteMask(byteMask));
    sdram_command_interface DUT (.sys_clk(sys_clk), .rstn(rstn), .cmdSelectN(strobeN[3]),
        .rowStrobeN(strobeN[2]), .colStrobeN(strobeN[1]), .writeStrobeN(strobeN[0]), .clockGate(clockGate),
        .addr(addr), .upperByteMask(byteMask[1]), .lowerByteMask(byteMask[0]), .storeData(storeData),
        .readData(readData), .dataOutEnN(dataOutEnN), .bankOpen(bankOpen), .modeReg(modeReg),
        .refreshRow(refreshRow), .burstActive(burstActive), .autoRefreshBusy(autoRefreshBusy),
        .selfRefresh(selfRefresh), .illegalCmd(illegalCmd));
    // compare one value
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errCount++;
            $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // no-op cycles, masks held, then settle past the edge
    task automatic idle(input int n, input logic [1:0] m);
        repeat (n) ctl.drive(4'h7, 10'h000, ~storeData, m, 1'b1);
        #1;
    endtask : idle
    // burst of two reads from bank 1 column 4
    task automatic readPair(input logic [1:0] m, input logic [1:0] en);
        ctl.drive(4'h5, 10'h204, 16'h0000, m, 1'b1);
        idle(2, m);
        cmp(dataOutEnN, en);
        cmp({m[1] ? 8'h12 : readData[15:8], readData[7:0]}, 16'h12FF);
        idle(1, m);
        cmp({m[1] ? 8'h56 : readData[15:8], readData[7:0]}, 16'h56FF);
        idle(1, m);
        cmp(dataOutEnN, 2'h3);
    endtask : readPair
    // read with autoclose on bank 0; burst length from mode bit 0
    task automatic autoClose(input logic [9:0] mode);
        ctl.drive(4'h0, mode, 16'h0000, 2'h0, 1'b1);
        ctl.drive(4'h3, 10'h005, 16'h0000, 2'h0, 1'b1);
        ctl.drive(4'h5, 10'h100, 16'h0000, 2'h0, 1'b1);
        idle(1, 2'h0);
        cmp({burstActive, bankOpen}, mode[0] ? 3'h5 : 3'h0);
        idle(1, 2'h0);
        cmp({burstActive, bankOpen}, 3'h0);
    endtask : autoClose
    // report and end the run
    task automatic closeOut();
        $display("mismatches %0d comparisons %0d", errCount, comparisons);
        if (errCount == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : closeOut
    // hang guard
    initial
    begin
        #100000;
        errCount++;
        closeOut();
    end
    // main sequence
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        cmp(modeReg, 10'h020);
        ctl.drive(4'h0, 10'h021, 16'h0000, 2'h0, 1'b1);
        idle(1, 2'h0);
        cmp(modeReg, 10'h021);
        ctl.drive(4'h3, 10'h205, 16'h0000, 2'h0, 1'b1);
        idle(1, 2'h0);
        cmp(bankOpen, 2'h2);
        ctl.drive(4'h4, 10'h204, 16'h1234, 2'h0, 1'b1);
        ctl.drive(4'h7, 10'h000, 16'h5678, 2'h0, 1'b1);
        ctl.drive(4'h4, 10'h204, 16'hFFFF, 2'h2, 1'b1);
        ctl.drive(4'h7, 10'h000, 16'hFFFF, 2'h2, 1'b1);
        readPair(2'h0, 2'h0);
        readPair(2'h2, 2'h2);
        ctl.drive(4'hB, 10'h000, 16'h0000, 2'h0, 1'b1);
        idle(1, 2'h0);
        cmp(bankOpen, 2'h2);
        ctl.drive(4'h7, 10'h000, 16'h0000, 2'h0, 1'b0);
        ctl.drive(4'h2, 10'h200, 16'h0000, 2'h0, 1'b1);
        idle(1, 2'h0);
        cmp(bankOpen, 2'h2);
        ctl.drive(4'h2, 10'h100, 16'h0000, 2'h0, 1'b1);
        idle(1, 2'h0);
        cmp(bankOpen, 2'h0);
        ctl.drive(4'h1, 10'h000, 16'h0000, 2'h0, 1'b1);
        idle(1, 2'h0);
        cmp(autoRefreshBusy, 1'b1);
        cmp(refreshRow, 10'h001);
        idle(6, 2'h0);
        ctl.drive(4'h1, 10'h000, 16'h0000, 2'h0, 1'b0);
        idle(1, 2'h0);
        cmp(selfRefresh, 1'b1);
        ctl.drive(4'h0, 10'h100, 16'h0000, 2'h0, 1'b1);
        idle(1, 2'h0);
        cmp({selfRefresh, illegalCmd}, 2'h1);
        autoClose(10'h021);
        autoClose(10'h020);
        closeOut();
    end
endmodule : sdram_command_interface_tb
